/* src/iosd_params.svh */
`ifndef IOSD_PARAMS_SVH
`define IOSD_PARAMS_SVH

// Register byte offsets
`define IOSD_CTRL_OFS      4'h0
`define IOSD_TERM_OFS      4'h4
`define IOSD_DISP_OFS      4'h8
`define IOSD_STAT_OFS      4'hC

// Control register fields
`define IOSD_CTRL_ITEM_LO  0
`define IOSD_CTRL_ITEM_HI  1
`define IOSD_CTRL_HEX      2
`define IOSD_CTRL_HEX_OUT  3
`define IOSD_CTRL_WIDTH    4
`define IOSD_CTRL_RESET    4'h0

// Terminal hex word bit positions
`define IOSD_IN_FWD_BIT    0
`define IOSD_IN_LINK_LO    13
`define IOSD_OUT_TR_BIT    0
`define IOSD_OUT_RELAY_BIT 8

// Segment codes: bit 0 is segment a up to bit 6 g, bit 7 dp
`define IOSD_SEG_A         8'h01
`define IOSD_SEG_DASH      8'h40
`define IOSD_SEG_BLANK     8'h00

`endif

/* src/iosd_pkg.sv */
package iosd_pkg;

	typedef enum logic [1:0] {
		IOSD_ITEM_RUN,
		IOSD_ITEM_TERM,
		IOSD_ITEM_LINK
	} iosd_item_t;

	typedef struct packed {
		logic [6:0]  sync1;
		logic [6:0]  sync2;
		logic [4:0]  term_in;
		logic [1:0]  term_out;
		logic [2:0]  link;
		logic [15:0] status;
		logic [3:0]  ctrl;
		logic [7:0]  led4;
		logic [7:0]  led3;
		logic [7:0]  led2;
		logic [7:0]  led1;
		logic        ack;
		logic [31:0] rdata;
	} iosd_state_t;

	// Lit segment is 1; b and d are lower case so they differ from 8 and 0
	function automatic logic [7:0] iosd_hex_glyph(input logic [3:0] nib);
		logic [7:0] g;
		g = 8'h00;
		case (nib)
			4'h0: g = 8'h3F;
			4'h1: g = 8'h06;
			4'h2: g = 8'h5B;
			4'h3: g = 8'h4F;
			4'h4: g = 8'h66;
			4'h5: g = 8'h6D;
			4'h6: g = 8'h7D;
			4'h7: g = 8'h07;
			4'h8: g = 8'h7F;
			4'h9: g = 8'h6F;
			4'hA: g = 8'h77;
			4'hB: g = 8'h7C;
			4'hC: g = 8'h39;
			4'hD: g = 8'h5E;
			4'hE: g = 8'h79;
			default: g = 8'h71;
		endcase
		return g;
	endfunction

endpackage

/* src/iosd_hex_digits.sv */
`timescale 1ns/1ps
`default_nettype none

module iosd_hex_digits (
	// Word to show
	input  wire logic [15:0] word,
	// Glyphs, leftmost digit first
	output logic      [31:0] glyphs
);
	import iosd_pkg::*;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			glyphs[i*8 +: 8] = iosd_hex_glyph(word[i*4 +: 4]);
		end
	end

endmodule

`default_nettype wire

/* src/iosd_display.sv */
// Summary of operation
// - Each nibble shown as hex glyph, MSD left
// - Segments a-e of right digit show inputs
// - Third digit segment a shows transistor output
// - Left digit segment a shows relay contact
// - No input active: dash on all digits
// - Second digit f, g, dp show link commands
// - Segment or hex view chosen by selection
// - Items for pin terminals and link terminals
// - Running-status word shown as four digits
// - Hex inputs: run bits 0-1, general 2-4
// - Hex outputs: transistor bit 0, relay 8
`timescale 1ns/1ps
`default_nettype none
`include "iosd_params.svh"

module iosd_display (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// Terminal pins
	input  wire logic        forward_run_input,
	input  wire logic        reverse_run_input,
	input  wire logic        general_input_one,
	input  wire logic        general_input_two,
	input  wire logic        general_input_three,
	input  wire logic        transistor_output,
	input  wire logic        relay_contact_output,
	// Serial link commands and drive status
	input  wire logic        link_forward_command,
	input  wire logic        link_reverse_command,
	input  wire logic        link_reset_command,
	input  wire logic [15:0] run_status,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// LED digits, led4 leftmost
	output logic      [7:0]  seg_led4,
	output logic      [7:0]  seg_led3,
	output logic      [7:0]  seg_led2,
	output logic      [7:0]  seg_led1
);
	import iosd_pkg::*;

	logic        rst_meta;
	logic        rst_sync;
	iosd_state_t st;
	iosd_state_t next_st;
	iosd_item_t  item;
	logic [15:0] in_word;
	logic [15:0] out_word;
	logic [15:0] hex_word;
	logic [31:0] hex_glyphs;
	logic [7:0]  sv4;
	logic [7:0]  sv3;
	logic [7:0]  sv2;
	logic [7:0]  sv1;
	logic        none_active;
	logic        req;

	// Reset release is synchronised so all state leaves reset on one edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	assign item = iosd_item_t'(st.ctrl[`IOSD_CTRL_ITEM_HI:`IOSD_CTRL_ITEM_LO]);

	// Link bits only belong to the link item
	always_comb begin
		in_word = 16'h0000;
		in_word[`IOSD_IN_FWD_BIT +: 5] = st.term_in;
		if (item == IOSD_ITEM_LINK) begin
			in_word[`IOSD_IN_LINK_LO +: 3] = st.link;
		end
		out_word = 16'h0000;
		out_word[`IOSD_OUT_TR_BIT] = st.term_out[0];
		out_word[`IOSD_OUT_RELAY_BIT] = st.term_out[1];
	end

	always_comb begin
		case (item)
			IOSD_ITEM_RUN:  hex_word = st.status;
			default:        hex_word = st.ctrl[`IOSD_CTRL_HEX_OUT] ? out_word : in_word;
		endcase
	end

	iosd_hex_digits u_hex (
		.word   (hex_word),
		.glyphs (hex_glyphs)
	);

	// Segment view of the terminal items
	always_comb begin
		sv1 = {3'b000, st.term_in};
		sv2 = `IOSD_SEG_BLANK;
		if (item == IOSD_ITEM_LINK) begin
			sv2 = {st.link, 5'b00000};
		end
		sv3 = st.term_out[0] ? `IOSD_SEG_A : `IOSD_SEG_BLANK;
		sv4 = st.term_out[1] ? `IOSD_SEG_A : `IOSD_SEG_BLANK;
		none_active = (st.term_in == 5'h00) && ((item != IOSD_ITEM_LINK) || (st.link == 3'h0));
		if (none_active) begin
			sv1 = sv1 | `IOSD_SEG_DASH;
			sv2 = sv2 | `IOSD_SEG_DASH;
			sv3 = sv3 | `IOSD_SEG_DASH;
			sv4 = sv4 | `IOSD_SEG_DASH;
		end
	end

	assign req = avs_read | avs_write;
	// One wait cycle per access so read data can come from a flip-flop
	assign avs_waitrequest = req & ~st.ack;
	assign avs_readdata = st.rdata;
	assign seg_led4 = st.led4;
	assign seg_led3 = st.led3;
	assign seg_led2 = st.led2;
	assign seg_led1 = st.led1;

	always_comb begin
		next_st = st;
		// Pins pass two flip-flops before anything reads them
		next_st.sync1 = {relay_contact_output, transistor_output, general_input_three,
			general_input_two, general_input_one, reverse_run_input, forward_run_input};
		next_st.sync2 = st.sync1;
		next_st.term_in = st.sync2[4:0];
		next_st.term_out = st.sync2[6:5];
		next_st.link = {link_reset_command, link_reverse_command, link_forward_command};
		next_st.status = run_status;
		// Run status is always hex; terminal items follow the view bit
		if (item == IOSD_ITEM_RUN || (st.ctrl[`IOSD_CTRL_HEX] && item != IOSD_ITEM_RUN
			&& (item == IOSD_ITEM_TERM || item == IOSD_ITEM_LINK))) begin
			next_st.led4 = hex_glyphs[31:24];
			next_st.led3 = hex_glyphs[23:16];
			next_st.led2 = hex_glyphs[15:8];
			next_st.led1 = hex_glyphs[7:0];
		end else if (item == IOSD_ITEM_TERM || item == IOSD_ITEM_LINK) begin
			next_st.led4 = sv4;
			next_st.led3 = sv3;
			next_st.led2 = sv2;
			next_st.led1 = sv1;
		end else begin
			next_st.led4 = `IOSD_SEG_BLANK;
			next_st.led3 = `IOSD_SEG_BLANK;
			next_st.led2 = `IOSD_SEG_BLANK;
			next_st.led1 = `IOSD_SEG_BLANK;
		end
		next_st.ack = req & ~st.ack;
		if (req && !st.ack) begin
			case (avs_address)
				`IOSD_CTRL_OFS: next_st.rdata = {28'h0000000, st.ctrl};
				`IOSD_TERM_OFS: next_st.rdata = {out_word, in_word};
				`IOSD_DISP_OFS: next_st.rdata = {st.led4, st.led3, st.led2, st.led1};
				`IOSD_STAT_OFS: next_st.rdata = {16'h0000, st.status};
				default:        next_st.rdata = 32'h00000000;
			endcase
		end
		if (avs_write && st.ack && avs_address == `IOSD_CTRL_OFS && avs_byteenable[0]) begin
			next_st.ctrl = avs_writedata[`IOSD_CTRL_WIDTH-1:0];
		end
	end

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			st <= '0;
			st.ctrl <= `IOSD_CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	a_run_hex_order: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_RUN) |=> (seg_led4 == iosd_hex_glyph($past(st.status[15:12])))
		&& (seg_led1 == iosd_hex_glyph($past(st.status[3:0]))))
		else $error("running status digits wrong");
	a_seg_fwd_lit: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && !st.ctrl[`IOSD_CTRL_HEX] && st.term_in[0]) |=> seg_led1[0])
		else $error("forward segment dark");
	a_seg_x1_dark: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && !st.ctrl[`IOSD_CTRL_HEX] && !st.term_in[2]) |=> !seg_led1[2])
		else $error("open input segment lit");
	a_seg_trans: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && !st.ctrl[`IOSD_CTRL_HEX])
		|=> (seg_led3[0] == $past(st.term_out[0])))
		else $error("transistor segment wrong");
	a_seg_relay: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && !st.ctrl[`IOSD_CTRL_HEX])
		|=> (seg_led4[0] == $past(st.term_out[1])))
		else $error("relay segment wrong");
	a_dash_row: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && !st.ctrl[`IOSD_CTRL_HEX] && st.term_in == 5'h00)
		|=> (seg_led4[6] && seg_led3[6] && seg_led2[6] && seg_led1[6]))
		else $error("dash row missing");
	a_link_segs: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_LINK && !st.ctrl[`IOSD_CTRL_HEX] && st.link == 3'h5)
		|=> (seg_led2[7:5] == 3'h5))
		else $error("link segments wrong");
	a_link_hidden: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && !st.ctrl[`IOSD_CTRL_HEX]) |=> (seg_led2[7] == 1'b0))
		else $error("link shown on pin item");
	a_hex_inputs: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && st.ctrl[`IOSD_CTRL_HEX] && !st.ctrl[`IOSD_CTRL_HEX_OUT]
		&& st.term_in == 5'h05) |=> (seg_led1 == 8'h6D && seg_led2 == 8'h3F))
		else $error("input hex word wrong");
	a_hex_outputs: assert property (@(posedge clock) disable iff (!rst_sync)
		(item == IOSD_ITEM_TERM && st.ctrl[`IOSD_CTRL_HEX] && st.ctrl[`IOSD_CTRL_HEX_OUT]
		&& st.term_out == 2'b11) |=> (seg_led1 == 8'h06 && seg_led3 == 8'h06))
		else $error("output hex word wrong");
	a_pin_sample: assert property (@(posedge clock) disable iff (!rst_sync)
		1'b1 |=> (st.term_in == $past(st.sync2[4:0])))
		else $error("terminal sample lost");

endmodule

`default_nettype wire

/* verif/iosd_led_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module iosd_led_monitor (
	// Digits from the block, led4 leftmost
	input  wire logic [31:0] digits,
	// Decoded word, and whether all four digits are glyphs
	output logic      [15:0] word,
	output logic             ok
);
	// Any other pattern is not a glyph, so a stray segment shows up as ok low
	localparam logic [7:0] GL [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
		8'h07, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
	always_comb begin
		word = 16'h0000;
		ok = 1'b1;
		for (int d = 0; d < 4; d++) begin
			logic hit;
			hit = 1'b0;
			for (int g = 0; g < 16; g++)
				if (digits[d*8 +: 8] === GL[g]) begin
					word[d*4 +: 4] = 4'(g);
					hit = 1'b1;
				end
			ok = ok & hit;
		end
	end
endmodule

`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iosd_params.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end

module tb;
	logic        clock = 1'b0;
	logic        nrst  = 1'b0;
	logic [6:0]  pins  = 7'h00;
	logic [2:0]  lnk   = 3'h0;
	logic [15:0] run   = 16'h8321;
	logic [3:0]  adr   = 4'h0;
	logic        rdq   = 1'b0;
	logic        wrq   = 1'b0;
	logic [31:0] wd    = 32'h0;
	logic [31:0] rdata;
	logic        wait_q;
	logic [7:0]  l4, l3, l2, l1;
	logic [15:0] word;
	logic        ok;
	logic [31:0] r;
	int          n_mismatch = 0;
	int          comparisons = 0;

	always #50 clock = ~clock;

	iosd_display dut_u (.clock(clock), .nrst(nrst), .forward_run_input(pins[0]),
		.reverse_run_input(pins[1]), .general_input_one(pins[2]),
		.general_input_two(pins[3]), .general_input_three(pins[4]),
		.transistor_output(pins[5]), .relay_contact_output(pins[6]),
		.link_forward_command(lnk[0]), .link_reverse_command(lnk[1]),
		.link_reset_command(lnk[2]), .run_status(run), .avs_address(adr),
		.avs_read(rdq), .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wait_q), .seg_led4(l4), .seg_led3(l3),
		.seg_led2(l2), .seg_led1(l1));

	iosd_led_monitor mon_u (.digits({l4, l3, l2, l1}), .word(word), .ok(ok));

	task automatic stop_test();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Request held up to the edge at which waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		adr <= a;
		wd <= d;
		wrq <= w;
		rdq <= !w;
		// Read before this edge's register updates land, as the slave sees it
		do begin
			@(posedge clock);
			n++;
		end while (wait_q !== 1'b0 && n < 50);
		r = rdata;
		rdq <= 1'b0;
		wrq <= 1'b0;
		if (n >= 50) begin
			`CHK("waitrequest", 1'b0, wait_q)
			stop_test();
		end
	endtask

	// Pin path is four edges deep; allow margin, then look between edges
	task automatic settle();
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic t_reset();
		repeat (8) @(posedge clock);
		`CHK("blank", 32'h0, {l4, l3, l2, l1})
		nrst <= 1'b1;
		settle();
		`CHK("status word", 16'h8321, word)
		bus(1'b0, `IOSD_CTRL_OFS, 0);
		`CHK("ctrl reset", 32'h0, r)
		$display("reset test done");
	endtask

	task automatic t_status();
		logic [15:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {4'(4*i+3), 4'(4*i+2), 4'(4*i+1), 4'(4*i)};
			run <= v;
			settle();
			`CHK("glyph word", v, word)
			`CHK("glyph ok", 1'b1, ok)
			bus(1'b1, `IOSD_STAT_OFS, 32'hFFFF);
			bus(1'b0, `IOSD_STAT_OFS, 0);
			`CHK("stat", {16'h0, v}, r)
		end
		bus(1'b0, 4'h1, 0);
		`CHK("unmapped", 32'h0, r)
		$display("status test done");
	endtask

	task automatic t_segment();
		bus(1'b1, `IOSD_CTRL_OFS, 32'h1);
		pins <= 7'h00;
		settle();
		`CHK("dashes", 32'h40404040, {l4, l3, l2, l1})
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			pins <= 7'(1 << i);
			settle();
			`CHK("input seg", {24'h0, 8'(1 << i)}, {l4, l3, l2, l1})
		end
		@(posedge clock);
		pins <= 7'h21;
		settle();
		`CHK("transistor seg", 32'h00010001, {l4, l3, l2, l1})
		@(posedge clock);
		pins <= 7'h41;
		settle();
		`CHK("relay seg", 32'h01000001, {l4, l3, l2, l1})
		$display("segment test done");
	endtask

	task automatic t_hex();
		bus(1'b1, `IOSD_CTRL_OFS, 32'h5);
		pins <= 7'h65;
		settle();
		`CHK("hex inputs", 16'h0005, word)
		bus(1'b1, `IOSD_CTRL_OFS, 32'hD);
		settle();
		`CHK("hex outputs", 16'h0101, word)
		bus(1'b0, `IOSD_TERM_OFS, 0);
		`CHK("term word", 32'h01010005, r)
		$display("hex test done");
	endtask

	task automatic t_link();
		pins <= 7'h00;
		bus(1'b1, `IOSD_CTRL_OFS, 32'h2);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			lnk <= 3'(1 << i);
			settle();
			`CHK("link seg", {16'h0, 8'(8'h20 << i), 8'h0}, {l4, l3, l2, l1})
		end
		@(posedge clock);
		lnk <= 3'h5;
		settle();
		`CHK("link pair", 32'h0000A000, {l4, l3, l2, l1})
		bus(1'b0, `IOSD_DISP_OFS, 0);
		`CHK("disp word", 32'h0000A000, r)
		bus(1'b1, `IOSD_CTRL_OFS, 32'h6);
		lnk <= 3'h7;
		pins <= 7'h01;
		settle();
		`CHK("link hex", 16'hE001, word)
		bus(1'b1, `IOSD_CTRL_OFS, 32'h3);
		settle();
		`CHK("item blank", 32'h0, {l4, l3, l2, l1})
		$display("link test done");
	endtask

	initial begin
		t_reset();
		t_status();
		t_segment();
		t_hex();
		t_link();
		stop_test();
	end
endmodule

`default_nettype wire
